/* design/rxdcr_top.sv */
// Receive-side sequencer, gain step, compound slicer and data/clock
// recovery, plus the small FIFO between bit sampler and output stage.
// Assumes slicer and flag pins are asynchronous to ref_clk and that the
// recovery enable and bit-rate setting come from configuration logic.
// Outputs are registered; the host samples them with its own clock.
`timescale 1ns/100ps
`default_nettype none

// Small FIFO with valid and ready on both sides and a flush input
module rxdcr_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Flush
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    // Power-of-two depth keeps pointer wrap free
    // and the full test simple; other depths are refused
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
            $error("rxdcr_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } rxdcr_fifo_state_t;

    rxdcr_fifo_state_t s_q;
    rxdcr_fifo_state_t s_d;
    logic [AW:0] fill;

    // Extra pointer bit tells full from empty
    // and, with a power-of-two depth, pointers wrap without a compare
    assign fill = s_q.wr - s_q.rd;
    // A full FIFO refuses a push even when a pop is taken the same cycle
    assign in_ready = (fill != (AW + 1)'(DEPTH));
    assign out_valid = (s_q.wr != s_q.rd);
    assign out_data = s_q.mem[s_q.rd[AW-1:0]];

    // Next state
    always_comb begin
        s_d = s_q;
        if (flush) begin
            // Unread words are dropped; the read side keeps its place
            s_d.wr = s_q.rd;
        end else begin
            if (in_valid && in_ready) begin
                s_d.mem[s_q.wr[AW-1:0]] = in_data;
                s_d.wr = s_q.wr + (AW + 1)'(1);
            end
            if (out_valid && out_ready) begin
                s_d.rd = s_q.rd + (AW + 1)'(1);
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : rxdcr_fifo

// Top level: sequencer, gain step, slicer path and recovery
module rxdcr_top
    import rxdcr_pkg::*;
#(
    parameter int unsigned FIFO_D = rxdcr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Amplifier control
    input wire logic saturation_onset_flag,
    input wire logic agc_reset,
    output logic first_rf_amp_en,
    output logic second_rf_amp_en,
    output logic gain_step_low,
    // Slicers
    input wire logic threshold_slicer,
    input wire logic peak_relative_slicer,
    input wire logic peak_slicer_used,
    // Configuration
    input wire logic recovery_enable,
    input wire logic [rxdcr_pkg::BIT_CNT_W-1:0] bit_period_cycles,
    // Host link
    output logic rx_serial_out,
    output logic rx_recovered_clock,
    output logic rx_overrun
);
    import rxdcr_pkg::*;

    // Windows must fit their half of the generator period
    // and the FIFO needs room for at least two bits in flight
    generate
        if (AMP_ON_CYC_I < 1 || AMP_ON_CYC_I > PG_PERIOD_CYC_I / 2
            || FIFO_D < 2) begin : g_chk
            $error("rxdcr_top: timing or FIFO depth out of range");
        end
    endgenerate

    // Settings below the minimum would leave no mid-bit point
    function automatic logic [BIT_CNT_W-1:0] eff_period(
        input logic [BIT_CNT_W-1:0] p);
        eff_period = (p < BIT_PERIOD_MIN) ? BIT_PERIOD_MIN : p;
    endfunction : eff_period

    // Window decode shared by both amplifiers; the difference form
    // avoids start plus length overflowing the narrow counter
    function automatic logic in_window(
        input logic [PG_CNT_W-1:0] cnt,
        input logic [PG_CNT_W-1:0] start);
        in_window = ((cnt - start) < AMP_ON_CYC);
    endfunction : in_window

    rxdcr_state_t s_q;
    rxdcr_state_t s_d;
    logic [N_PINS-1:0] pins;
    logic [BIT_CNT_W-1:0] period;
    logic [BIT_CNT_W-1:0] half;
    logic sample_tick;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic pop_ready;
    logic pop_data;
    logic rec_en;

    // Pins gathered for the synchroniser
    assign pins[PIN_SAT] = saturation_onset_flag;
    assign pins[PIN_AGC_RST] = agc_reset;
    assign pins[PIN_THR] = threshold_slicer;
    assign pins[PIN_PEAK] = peak_relative_slicer;
    assign pins[PIN_PEAK_USED] = peak_slicer_used;
    assign pins[PIN_REC_EN] = recovery_enable;

    // Bit timing from the rate setting
    assign period = eff_period(bit_period_cycles);
    // Odd periods round down, so the clock's high phase is the longer
    assign half = period >> 1;
    assign sample_tick = (s_q.bit_cnt == half);
    assign rec_en = s_q.sync2[PIN_REC_EN];

    // Sampler pushes bits only once locked to a start pattern
    assign push_valid = sample_tick && (s_q.rstate == RS_LOCKED);
    // Output stage takes a new bit only when its pulse has ended,
    // so a slow pulse stage never drops a bit already queued
    assign pop_ready = (s_q.rstate == RS_LOCKED) && (s_q.ph_cnt == BIT_CNT_ZERO);

    rxdcr_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .flush(s_q.rstate != RS_LOCKED),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(s_q.comp),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );

    // Next state of the whole block
    always_comb begin
        s_d = s_q;

        // Two-stage synchroniser; only sync2 feeds logic. The first
        // stage may go metastable, so nothing else ever reads it.
        for (int i = 0; i < N_PINS; i++) begin
            s_d.sync1[i] = pins[i];
            s_d.sync2[i] = s_q.sync1[i];
        end

        // Pulse generator: one counter drives both windows, so
        // the enables are decoded from disjoint ranges. Decoding the
        // present count makes the first window after reset full length.
        // The period count is rounded down from the generator rate.
        s_d.pg_cnt = (s_q.pg_cnt == PG_LAST) ? PG_CNT_W'(0)
                   : s_q.pg_cnt + PG_CNT_W'(1);
        s_d.amp1 = in_window(s_q.pg_cnt, AMP1_START);
        s_d.amp2 = in_window(s_q.pg_cnt, AMP2_START)
                && !s_d.amp1;

        // Gain step: saturation sets low gain, peak reset restores;
        // set wins if both arrive together
        // The flag is a level, so lasting saturation holds low gain
        if (s_q.sync2[PIN_SAT]) begin
            s_d.gain_low = GAIN_LOW_5DB;
        end else if (s_q.sync2[PIN_AGC_RST]) begin
            s_d.gain_low = GAIN_HIGH_35DB;
        end

        // Compound slicer; threshold slicer always takes part
        // An unused peak slicer is ignored, so its noise cannot gate data
        s_d.comp = s_q.sync2[PIN_THR]
                && (s_q.sync2[PIN_PEAK] || !s_q.sync2[PIN_PEAK_USED]);
        s_d.comp_prev = s_q.comp;

        // Bit timer resyncs on each data edge
        // Restarting at one allows for the edge being seen a cycle late,
        // so the sample at half a period falls near mid-bit
        if (s_q.comp != s_q.comp_prev) begin
            s_d.bit_cnt = BIT_CNT_ONE;
        end else if (s_q.bit_cnt >= period - BIT_CNT_ONE) begin
            s_d.bit_cnt = BIT_CNT_ZERO;
        end else begin
            s_d.bit_cnt = s_q.bit_cnt + BIT_CNT_ONE;
        end

        // Recovered clock pulse: high first half, low second half
        if (s_q.ph_cnt != BIT_CNT_ZERO) begin
            s_d.ph_cnt = s_q.ph_cnt - BIT_CNT_ONE;
            if (s_q.ph_cnt == half) begin
                s_d.out_clk = 1'b0;
            end
        end

        // Recovery walk for a period of P cycles: the last start bit is
        // sampled and the state locks; P cycles later the first data bit
        // is sampled into the FIFO; the next cycle pops it, puts it on
        // the data pin and raises the clock; the clock drops once the
        // pulse counter reaches P/2, so the host's falling-edge sample
        // finds the data long settled. With the FIFO empty the clock
        // simply waits low, which a host sees as a slower bit.
        // The FIFO absorbs the phase slip between the sampler, which
        // resyncs on every data edge, and the pulse stage.
        case (s_q.rstate)
            RS_IDLE: begin
                // Stale bits are dropped so they cannot complete a pattern
                s_d.out_clk = 1'b0;
                s_d.ph_cnt = BIT_CNT_ZERO;
                s_d.overrun = 1'b0;
                s_d.shift = '0;
                if (rec_en) begin
                    s_d.rstate = RS_SEARCH;
                end
            end
            RS_SEARCH: begin
                s_d.out_clk = 1'b0;
                if (!rec_en) begin
                    s_d.rstate = RS_IDLE;
                end else if (sample_tick) begin
                    // Oldest bit ends up in the top position
                    s_d.shift = {s_q.shift[START_W-2:0], s_q.comp};
                    if (s_d.shift == START_PATTERN) begin
                        s_d.rstate = RS_LOCKED;
                    end
                end
            end
            RS_LOCKED: begin
                if (!rec_en) begin
                    // Clearing the enable is the only way out
                    // A pulse in flight is cut short here
                    s_d.rstate = RS_IDLE;
                    s_d.out_clk = 1'b0;
                end else begin
                    // A bit that finds the FIFO full is lost; the flag
                    // stays up until recovery is switched off
                    if (push_valid && !push_ready) begin
                        s_d.overrun = 1'b1;
                    end
                    // First pop lands at mid of first data bit
                    if (pop_ready && pop_valid) begin
                        s_d.out_data = pop_data;
                        s_d.out_clk = 1'b1;
                        s_d.ph_cnt = period - BIT_CNT_ONE;
                    end
                end
            end
            default: begin
                s_d.rstate = RS_IDLE;
            end
        endcase

        // Before lock the pin follows the slicer with no retiming,
        // at a fixed latency, so a host slicing raw bits sees no jitter
        if (s_d.rstate != RS_LOCKED) begin
            s_d.out_data = s_d.comp;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    // so no output glitches on a combinational path
    assign first_rf_amp_en = s_q.amp1;
    assign second_rf_amp_en = s_q.amp2;
    assign gain_step_low = s_q.gain_low;
    assign rx_serial_out = s_q.out_data;
    assign rx_recovered_clock = s_q.out_clk;
    assign rx_overrun = s_q.overrun;
endmodule : rxdcr_top

`default_nettype wire

/* design/rxdcr_pkg.sv */
// Constants, types and state layout for the receive sequencer and
// data/clock recovery block.
// Assumes a 10 MHz core clock; all times below are turned into cycle
// counts against that rate.
package rxdcr_pkg;

    // Core clock
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;

    // Amplifier sequencer timing
    localparam int unsigned PG_FREQ_HZ = 614_000;
    localparam int unsigned AMP_ON_TIME_NS = 814;
    // Longest on-time, so round down
    localparam int unsigned AMP_ON_CYC_I = AMP_ON_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned PG_PERIOD_CYC_I = CLK_HZ / PG_FREQ_HZ;
    localparam int unsigned PG_CNT_W = $clog2(PG_PERIOD_CYC_I);
    localparam logic [PG_CNT_W-1:0] PG_LAST =
        PG_CNT_W'(PG_PERIOD_CYC_I - 1);
    localparam logic [PG_CNT_W-1:0] AMP1_START = PG_CNT_W'(0);
    localparam logic [PG_CNT_W-1:0] AMP2_START =
        PG_CNT_W'(PG_PERIOD_CYC_I / 2);
    localparam logic [PG_CNT_W-1:0] AMP_ON_CYC = PG_CNT_W'(AMP_ON_CYC_I);

    // Gain step encodings of the first amplifier
    localparam logic GAIN_HIGH_35DB = 1'b0;
    localparam logic GAIN_LOW_5DB = 1'b1;

    // Start pattern, sent most significant bit first
    localparam int unsigned START_W = 16;
    localparam logic [START_W-1:0] START_PATTERN = 16'hE2E2;

    // Bit-rate setting, in core clock cycles per bit
    localparam int unsigned BIT_CNT_W = 16;
    localparam logic [BIT_CNT_W-1:0] BIT_PERIOD_MIN = 16'h0004;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 16'h0000;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 16'h0001;

    // Synchroniser bit positions for the pins
    localparam int unsigned N_PINS = 6;
    localparam int unsigned PIN_SAT = 0;
    localparam int unsigned PIN_AGC_RST = 1;
    localparam int unsigned PIN_THR = 2;
    localparam int unsigned PIN_PEAK = 3;
    localparam int unsigned PIN_PEAK_USED = 4;
    localparam int unsigned PIN_REC_EN = 5;

    // Recovered-bit FIFO
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_WIDTH = 1;

    // Recovery state
    typedef enum logic [1:0] {
        RS_IDLE,
        RS_SEARCH,
        RS_LOCKED
    } rxdcr_rstate_t;

    // Whole state of the top module
    typedef struct packed {
        logic [N_PINS-1:0] sync1;
        logic [N_PINS-1:0] sync2;
        logic [PG_CNT_W-1:0] pg_cnt;
        logic amp1;
        logic amp2;
        logic gain_low;
        logic comp;
        logic comp_prev;
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic [START_W-1:0] shift;
        rxdcr_rstate_t rstate;
        logic [BIT_CNT_W-1:0] ph_cnt;
        logic out_data;
        logic out_clk;
        logic overrun;
    } rxdcr_state_t;

endpackage : rxdcr_pkg

/* test/rxdcr_chk.sv */
// Port checker for rxdcr_top: sequencer, gain step, slicer path, link.
// Sees only the top module's ports; bound in at the foot of this file.
`timescale 1ns/100ps
`default_nettype none
module rxdcr_chk
    import rxdcr_pkg::*;
#(parameter int unsigned FIFO_D = 8) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Amplifier control
    input wire logic saturation_onset_flag,
    input wire logic agc_reset,
    input wire logic first_rf_amp_en,
    input wire logic second_rf_amp_en,
    input wire logic gain_step_low,
    // Slicers and configuration
    input wire logic threshold_slicer,
    input wire logic peak_relative_slicer,
    input wire logic peak_slicer_used,
    input wire logic recovery_enable,
    input wire logic [rxdcr_pkg::BIT_CNT_W-1:0] bit_period_cycles,
    // Host link
    input wire logic rx_serial_out,
    input wire logic rx_recovered_clock,
    input wire logic rx_overrun
);
    logic [3:0] off_q;
    logic comp;
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Cycles with recovery off; saturates so a long idle never wraps
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_q <= 4'h0;
        end else if (recovery_enable) begin
            off_q <= 4'h0;
        end else if (off_q != 4'hF) begin
            off_q <= off_q + 4'h1;
        end
    end
    // Compound slicer as seen at the pins
    assign comp = threshold_slicer
        & (peak_relative_slicer | ~peak_slicer_used);
    amp_excl_a:
        assert property (!(first_rf_amp_en && second_rf_amp_en))
        else $error("both amplifiers on");
    amp1_win_a:
        assert property ($rose(first_rf_amp_en) |->
            first_rf_amp_en[*8] ##1 !first_rf_amp_en)
        else $error("first amplifier window wrong");
    amp2_win_a:
        assert property ($rose(second_rf_amp_en) |-> second_rf_amp_en[*8]
            ##1 (first_rf_amp_en && !second_rf_amp_en))
        else $error("second amplifier window wrong");
    gain_set_a:
        assert property (saturation_onset_flag[*3] |=>
            gain_step_low == GAIN_LOW_5DB)
        else $error("gain not stepped down");
    gain_clr_a:
        assert property ((agc_reset && !saturation_onset_flag)[*4] |=>
            gain_step_low == GAIN_HIGH_35DB)
        else $error("gain not restored");
    pass_thru_a:
        assert property (off_q > 4'h7 |-> rx_serial_out == $past(comp, 3))
        else $error("serial out not the slicer");
    clk_idle_a:
        assert property (off_q > 4'h3 |-> !rx_recovered_clock && !rx_overrun)
        else $error("recovered clock active while off");
    clk_keep_a:
        assert property ($fell(rx_recovered_clock) && recovery_enable |->
            ##[1:40] (rx_recovered_clock || !recovery_enable))
        else $error("recovered clock stopped");
endmodule : rxdcr_chk
bind rxdcr_top rxdcr_chk #(.FIFO_D(FIFO_D)) u_chk (.*);
`default_nettype wire

/* test/rxdcr_host.sv */
// Host model: takes each data bit at the recovered clock's falling edge
// and clears the recovery enable once a packet is complete.
// Assumes clock and data come straight from the device pins.
`timescale 1ns/100ps
`default_nettype none
module rxdcr_host #(parameter int unsigned NBITS = 8) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Listen request from the bench
    input wire logic arm,
    // Device pins
    input wire logic rx_serial_out,
    input wire logic rx_recovered_clock,
    output logic recovery_enable,
    // Received bits
    output logic got_valid,
    output logic got_bit
);
    logic clk_prev;
    int count;
    // Edge finder; bits past the packet are ignored, as a real host would
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            recovery_enable <= 1'b0;
            clk_prev <= 1'b0;
            got_valid <= 1'b0;
            got_bit <= 1'b0;
            count <= 0;
        end else begin
            clk_prev <= rx_recovered_clock;
            got_valid <= 1'b0;
            if (arm) begin
                recovery_enable <= 1'b1;
                count <= 0;
            end else if (recovery_enable && clk_prev && !rx_recovered_clock) begin
                got_valid <= 1'b1;
                got_bit <= rx_serial_out;
                count <= count + 1;
                if (count == NBITS - 1) begin
                    recovery_enable <= 1'b0;
                end
            end
        end
    end
endmodule : rxdcr_host
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for rxdcr_top with the host model on the link.
// Assumes a 10 MHz core clock and an 800 ns bit on the slicer pins.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import rxdcr_pkg::*;
    localparam int unsigned NBITS = 8;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic saturation_onset_flag = 1'b0;
    logic agc_reset = 1'b0;
    logic threshold_slicer = 1'b0;
    logic peak_relative_slicer = 1'b0;
    logic peak_slicer_used = 1'b0;
    logic arm = 1'b0;
    logic first_rf_amp_en, second_rf_amp_en, gain_step_low;
    logic rx_serial_out, rx_recovered_clock, rx_overrun;
    logic recovery_enable, got_valid, got_bit;
    logic exp_q[$];
    int failures = 0;
    int samples_checked = 0;
    int seed = 32'h273E265C;

    always #50 ref_clk = ~ref_clk;

    rxdcr_top #(.FIFO_D(8)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .saturation_onset_flag(saturation_onset_flag),
        .agc_reset(agc_reset), .first_rf_amp_en(first_rf_amp_en),
        .second_rf_amp_en(second_rf_amp_en), .gain_step_low(gain_step_low),
        .threshold_slicer(threshold_slicer),
        .peak_relative_slicer(peak_relative_slicer),
        .peak_slicer_used(peak_slicer_used),
        .recovery_enable(recovery_enable), .bit_period_cycles(16'h0008),
        .rx_serial_out(rx_serial_out),
        .rx_recovered_clock(rx_recovered_clock), .rx_overrun(rx_overrun));
    rxdcr_host #(.NBITS(NBITS)) u_host (.ref_clk(ref_clk), .rst_n(rst_n),
        .arm(arm), .rx_serial_out(rx_serial_out),
        .rx_recovered_clock(rx_recovered_clock),
        .recovery_enable(recovery_enable), .got_valid(got_valid),
        .got_bit(got_bit));

    task automatic check(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask : check

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // One link bit; with the peak slicer unused its pin is noise
    task automatic send_bit(input logic b, input logic used);
        peak_slicer_used <= used;
        threshold_slicer <= used ? 1'b1 : b;
        peak_relative_slicer <= used ? b : 1'($random(seed));
        repeat (8) @(posedge ref_clk);
    endtask : send_bit

    // Random slicer activity with recovery off
    task automatic noise();
        repeat (40) begin
            threshold_slicer <= 1'($random(seed));
            peak_relative_slicer <= 1'($random(seed));
            peak_slicer_used <= 1'($random(seed));
            @(posedge ref_clk);
        end
    endtask : noise

    // Arm the host, send a quiet lead-in, the start word, then data
    task automatic packet(input logic used);
        logic b;
        arm <= 1'b1;
        @(posedge ref_clk);
        arm <= 1'b0;
        repeat (8) send_bit(1'b0, used);
        for (int i = 15; i >= 0; i--) send_bit(START_PATTERN[i], used);
        for (int i = 0; i < NBITS; i++) begin
            b = 1'($random(seed));
            exp_q.push_back(b);
            send_bit(b, used);
        end
        repeat (24) @(posedge ref_clk);
        check("bits missing", 1'b0, exp_q.size() != 0);
    endtask : packet

    // Each bit the host takes is matched with the oldest expectation
    always @(posedge ref_clk) begin
        if (got_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("early clock", 1'b0, 1'b1);
            end else begin
                check("data bit", exp_q.pop_front(), got_bit);
            end
        end
    end

    // About thirty times the expected run length
    initial begin
        #2_000_000;
        failures++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        noise();
        saturation_onset_flag <= 1'b1;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check("gain step", GAIN_LOW_5DB, gain_step_low);
        @(posedge ref_clk);
        saturation_onset_flag <= 1'b0;
        agc_reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check("gain step", GAIN_HIGH_35DB, gain_step_low);
        @(posedge ref_clk);
        agc_reset <= 1'b0;
        packet(1'b1);
        noise();
        packet(1'b0);
        check("overrun", 1'b0, rx_overrun);
        test_done();
    end
endmodule : tb
`default_nettype wire
